// [rtl/sdcr_pkg.sv]
// Purpose: shared constants for the synthesizer divider configuration link
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: field positions and timing in one place
`default_nettype none

package sdcr_pkg;
  // ***************************************************
  // word layout
  // ***************************************************
  localparam int WORD_W = 32;
  localparam int SEL_W = 4;
  localparam int BITCNT_W = 5;
  localparam logic [3:0] SEL_INT = 4'h0;
  localparam logic [3:0] SEL_FRAC = 4'h1;
  localparam logic [3:0] SEL_AUX = 4'h2;
  localparam logic [3:0] SEL_PHASE = 4'h3;
  localparam logic [3:0] SEL_REF = 4'h4;
  localparam logic [3:0] SEL_OUTDIV = 4'h6;
  localparam logic [3:0] SEL_LAST = 4'hc;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // register 0
  localparam int INT_LSB = 4;
  localparam int INT_MSB = 19;
  localparam int PRESC_BIT = 20;
  localparam int AUTOCAL_BIT = 21;
  localparam logic [31:0] R0_KEEP = 32'h003f_ffff;
  localparam logic [15:0] INT_MIN_45 = 16'h0017;
  localparam logic [15:0] INT_MAX_45 = 16'h7fff;
  localparam logic [15:0] INT_MIN_89 = 16'h004b;
  // register 1
  localparam int MAIN_FRACTION_NUMERATOR_LSB = 4;
  localparam int MAIN_FRACTION_NUMERATOR_MSB = 27;
  localparam logic [31:0] R1_KEEP = 32'h0fff_ffff;
  // register 2
  localparam int AUX_FRACTION_MODULUS_LSB = 4;
  localparam int AUX_FRACTION_MODULUS_MSB = 17;
  localparam int AUX_FRACTION_NUMERATOR_LSB = 18;
  localparam int AUX_FRACTION_NUMERATOR_MSB = 31;
  // register 3
  localparam int PHASE_W = 24;
  localparam int PHASE_LSB = 4;
  localparam int PHASE_MSB = 27;
  localparam int PADJ_BIT = 28;
  localparam int RESYNC_BIT = 29;
  localparam int SDDIS_BIT = 30;
  localparam logic [31:0] R3_KEEP = 32'h7fff_ffff;
  // register 4
  localparam int CNTRST_BIT = 4;
  localparam int MUXLVL_BIT = 8;
  localparam int REFMODE_BIT = 9;
  localparam int CP_LSB = 10;
  localparam int CP_MSB = 13;
  localparam int DBLBUF_BIT = 14;
  localparam int RCNT_LSB = 15;
  localparam int RCNT_MSB = 24;
  localparam int HALF_BIT = 25;
  localparam int DOUBLER_BIT = 26;
  localparam int MUX_LSB = 27;
  localparam int MUX_MSB = 29;
  localparam logic [31:0] R4_KEEP = 32'h3fff_ffff;
  localparam logic [9:0] RCNT_ONE = 10'h001;
  // register 6
  localparam int OUTDIV_LSB = 21;
  localparam int OUTDIV_MSB = 23;
  // ***************************************************
  // host side
  // ***************************************************
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REJECT = 1;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] HALF_MIN = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_LOAD} sdcr_shift_t;
endpackage : sdcr_pkg

`default_nettype wire

// [rtl/sdcr_if.sv]
// Purpose: three-wire serial link between host and divider register bank
// Assumes: all wires synchronous to the system clock
// Notes: host drives every wire; device only listens
`default_nettype none

interface sdcr_if;
  logic ser_clk;
  logic ser_data;
  logic ser_load;
  modport host (output ser_clk, output ser_data, output ser_load);
  modport dev (input ser_clk, input ser_data, input ser_load);
endinterface : sdcr_if

`default_nettype wire

// [rtl/sdcr_device.sv]
// Purpose: divider configuration register bank with serial loader
// Assumes: link pins synchronous to i_mclk, at least two clocks per level
// Notes: registers 1 to 4 staged until register 0 is written
`default_nettype none

module sdcr_device (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // serial link
  sdcr_if.dev link,
  // reference input level
  input wire logic i_ref_in,
  // register 0 fields
  output logic [15:0] o_int_value,
  output logic o_presc_89,
  output logic o_int_range_err,
  output logic o_autocal_start,
  // fraction fields
  output logic [23:0] o_main_fraction_numerator,
  output logic [13:0] o_aux_fraction_numerator,
  output logic [13:0] o_aux_fraction_modulus,
  output logic o_modulator_reset,
  // phase control
  output logic o_resync_active,
  output logic o_phase_step,
  output logic [23:0] o_phase_accum,
  // reference path and misc
  output logic [2:0] o_mux_select,
  output logic [3:0] o_pump_current_code,
  output logic o_ref_differential,
  output logic o_mux_level_33,
  output logic o_counter_hold,
  output logic [2:0] o_out_div_select,
  output logic o_pfd_tick
);

  // ***************************************************
  // serial receiver
  // ***************************************************
  logic sclk_q;
  logic load_q;
  logic [31:0] shift;
  logic wr_stb;
  logic [31:0] wr_word;
  logic [3:0] wr_sel;
  logic commit;

  assign wr_sel = wr_word[sdcr_pkg::SEL_W-1:0];
  assign commit = wr_stb && (wr_sel == sdcr_pkg::SEL_INT);

  // edge history of link pins
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
      load_q <= 1'b0;
    end else if (i_ce) begin
      sclk_q <= link.ser_clk;
      load_q <= link.ser_load;
    end
  end

  // shift msb first on rising serial clock
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      shift <= sdcr_pkg::WORD_RESET;
    end else if (i_ce && link.ser_clk && !sclk_q) begin
      shift <= {shift[30:0], link.ser_data};
    end
  end

  // latch whole word on rising load strobe
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_stb <= 1'b0;
      wr_word <= sdcr_pkg::WORD_RESET;
    end else if (i_ce) begin
      wr_stb <= link.ser_load && !load_q;
      if (link.ser_load && !load_q) begin
        wr_word <= shift;
      end
    end
  end

  // ***************************************************
  // register bank
  // ***************************************************
  logic [31:0] active0;
  logic [31:0] staged [1:4];
  logic [31:0] active [1:4];
  logic [2:0] outdiv_staged;

  // register 0 is never buffered
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      active0 <= sdcr_pkg::WORD_RESET;
    end else if (i_ce && commit) begin
      active0 <= wr_word;
    end
  end

  // registers 1 to 4: stage on own write, go live on register 0 write
  for (genvar g = 1; g <= 4; g++) begin : g_dbuf
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        staged[g] <= sdcr_pkg::WORD_RESET;
        active[g] <= sdcr_pkg::WORD_RESET;
      end else if (i_ce) begin
        if (wr_stb && (wr_sel == 4'(g))) begin
          staged[g] <= wr_word;
        end
        if (commit) begin
          active[g] <= staged[g];
        end
      end
    end
  end

  // output divider select from register 6
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      outdiv_staged <= 3'h0;
      o_out_div_select <= 3'h0;
    end else if (i_ce) begin
      if (wr_stb && (wr_sel == sdcr_pkg::SEL_OUTDIV)) begin
        outdiv_staged <= wr_word[sdcr_pkg::OUTDIV_MSB:sdcr_pkg::OUTDIV_LSB];
        if (!active[4][sdcr_pkg::DBLBUF_BIT]) begin
          o_out_div_select <= wr_word[sdcr_pkg::OUTDIV_MSB:sdcr_pkg::OUTDIV_LSB];
        end
      end else if (commit && active[4][sdcr_pkg::DBLBUF_BIT]) begin
        o_out_div_select <= outdiv_staged;
      end
    end
  end

  // ***************************************************
  // events of a register 0 write
  // ***************************************************
  logic [15:0] next_int;
  assign next_int = wr_word[sdcr_pkg::INT_MSB:sdcr_pkg::INT_LSB];

  // calibration, modulator reset, phase step pulses
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_autocal_start <= 1'b0;
      o_modulator_reset <= 1'b0;
      o_phase_step <= 1'b0;
      o_phase_accum <= 24'h00_0000;
    end else if (i_ce) begin
      o_autocal_start <= commit && wr_word[sdcr_pkg::AUTOCAL_BIT];
      o_modulator_reset <= commit && !staged[3][sdcr_pkg::SDDIS_BIT];
      o_phase_step <= commit && staged[3][sdcr_pkg::PADJ_BIT];
      if (commit && staged[3][sdcr_pkg::PADJ_BIT]) begin
        // 24-bit wrap is one full turn of 360 degrees
        o_phase_accum <= o_phase_accum
          + staged[3][sdcr_pkg::PHASE_MSB:sdcr_pkg::PHASE_LSB];
      end
    end
  end

  // integer value below the prescaler floor or above 4/5 ceiling
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_int_range_err <= 1'b0;
    end else if (i_ce && commit) begin
      o_int_range_err <= wr_word[sdcr_pkg::PRESC_BIT]
        ? (next_int < sdcr_pkg::INT_MIN_89)
        : ((next_int < sdcr_pkg::INT_MIN_45) || (next_int > sdcr_pkg::INT_MAX_45));
    end
  end

  // live field views, straight from flip-flops except the gated resync flag
  assign o_int_value = active0[sdcr_pkg::INT_MSB:sdcr_pkg::INT_LSB];
  assign o_presc_89 = active0[sdcr_pkg::PRESC_BIT];
  assign o_main_fraction_numerator = active[1][sdcr_pkg::MAIN_FRACTION_NUMERATOR_MSB:sdcr_pkg::MAIN_FRACTION_NUMERATOR_LSB];
  assign o_aux_fraction_numerator = active[2][sdcr_pkg::AUX_FRACTION_NUMERATOR_MSB:sdcr_pkg::AUX_FRACTION_NUMERATOR_LSB];
  assign o_aux_fraction_modulus = active[2][sdcr_pkg::AUX_FRACTION_MODULUS_MSB:sdcr_pkg::AUX_FRACTION_MODULUS_LSB];
  // resync only with zero aux fraction and modulator reset on
  assign o_resync_active = active[3][sdcr_pkg::RESYNC_BIT]
    && !active[3][sdcr_pkg::SDDIS_BIT]
    && (o_aux_fraction_numerator == 14'h0000);
  assign o_mux_select = active[4][sdcr_pkg::MUX_MSB:sdcr_pkg::MUX_LSB];
  assign o_pump_current_code = active[4][sdcr_pkg::CP_MSB:sdcr_pkg::CP_LSB];
  assign o_ref_differential = active[4][sdcr_pkg::REFMODE_BIT];
  assign o_mux_level_33 = active[4][sdcr_pkg::MUXLVL_BIT];
  assign o_counter_hold = active[4][sdcr_pkg::CNTRST_BIT];

  // ***************************************************
  // reference path
  // ***************************************************
  logic ref_q;
  logic ref_edge;
  logic [9:0] rcnt;
  logic [9:0] ratio;
  logic half_tog;
  logic rcnt_wrap;

  assign ratio = active[4][sdcr_pkg::RCNT_MSB:sdcr_pkg::RCNT_LSB];
  // falling edge only, or both edges when doubled
  assign ref_edge = active[4][sdcr_pkg::DOUBLER_BIT]
    ? (ref_q ^ i_ref_in) : (ref_q && !i_ref_in);
  // ratio zero is treated as one
  assign rcnt_wrap = ref_edge && ((rcnt + sdcr_pkg::RCNT_ONE) >= ratio);

  // reference counter with optional toggle stage
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ref_q <= 1'b0;
      rcnt <= 10'h000;
      half_tog <= 1'b0;
      o_pfd_tick <= 1'b0;
    end else if (i_ce) begin
      ref_q <= i_ref_in;
      if (o_counter_hold) begin
        rcnt <= 10'h000;
        half_tog <= 1'b0;
        o_pfd_tick <= 1'b0;
      end else begin
        if (rcnt_wrap) begin
          rcnt <= 10'h000;
          half_tog <= !half_tog;
        end else if (ref_edge) begin
          rcnt <= rcnt + sdcr_pkg::RCNT_ONE;
        end
        o_pfd_tick <= rcnt_wrap
          && (!active[4][sdcr_pkg::HALF_BIT] || half_tog);
      end
    end
  end

endmodule : sdcr_device

`default_nettype wire

// [rtl/sdcr_host.sv]
// Purpose: AXI4-Lite slave that checks and shifts words to the register bank
// Assumes: serial half period is divider plus two system clocks
// Notes: invalid words and data writes while busy are answered with SLVERR
`default_nettype none

module sdcr_host (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  sdcr_if.host link,
  // status
  output logic o_busy
);

  // clear reserved bits that must go out as zero
  function automatic logic [31:0] mask_word(input logic [31:0] w);
    case (w[sdcr_pkg::SEL_W-1:0])
      sdcr_pkg::SEL_INT: mask_word = w & sdcr_pkg::R0_KEEP;
      sdcr_pkg::SEL_FRAC: mask_word = w & sdcr_pkg::R1_KEEP;
      sdcr_pkg::SEL_PHASE: mask_word = w & sdcr_pkg::R3_KEEP;
      sdcr_pkg::SEL_REF: mask_word = w & sdcr_pkg::R4_KEEP;
      default: mask_word = w;
    endcase
  endfunction : mask_word

  // refuse settings the bank cannot use
  function automatic logic word_ok(input logic [31:0] w);
    logic [15:0] iv;
    iv = w[sdcr_pkg::INT_MSB:sdcr_pkg::INT_LSB];
    case (w[sdcr_pkg::SEL_W-1:0])
      sdcr_pkg::SEL_INT: word_ok = w[sdcr_pkg::PRESC_BIT]
        ? (iv >= sdcr_pkg::INT_MIN_89)
        : ((iv >= sdcr_pkg::INT_MIN_45) && (iv <= sdcr_pkg::INT_MAX_45));
      sdcr_pkg::SEL_AUX: word_ok = w[sdcr_pkg::AUX_FRACTION_NUMERATOR_MSB:sdcr_pkg::AUX_FRACTION_NUMERATOR_LSB]
        < w[sdcr_pkg::AUX_FRACTION_MODULUS_MSB:sdcr_pkg::AUX_FRACTION_MODULUS_LSB];
      sdcr_pkg::SEL_PHASE: word_ok =
        !(w[sdcr_pkg::PADJ_BIT] && w[sdcr_pkg::RESYNC_BIT])
        && !(w[sdcr_pkg::PADJ_BIT] && !w[sdcr_pkg::SDDIS_BIT])
        && !(w[sdcr_pkg::RESYNC_BIT] && w[sdcr_pkg::SDDIS_BIT]);
      default: word_ok = (w[sdcr_pkg::SEL_W-1:0] <= sdcr_pkg::SEL_LAST);
    endcase
  endfunction : word_ok

  // ***************************************************
  // write channel
  // ***************************************************
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [7:0] half_div;
  logic reject;
  logic start;
  logic do_write;
  sdcr_pkg::sdcr_shift_t state;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign start = do_write && (aw_addr == sdcr_pkg::ADDR_DATA) && !o_busy && word_ok(w_data);
  assign o_busy = (state != sdcr_pkg::SH_IDLE);

  // hold address and data until both arrived
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= sdcr_pkg::WORD_RESET;
    end else if (i_ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // register effects and write response
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sdcr_pkg::RESP_OKAY;
      half_div <= sdcr_pkg::DIV_RESET;
      reject <= 1'b0;
    end else if (i_ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= sdcr_pkg::RESP_OKAY;
        case (aw_addr)
          sdcr_pkg::ADDR_DATA: begin
            if (!start) begin
              s_axi_bresp <= sdcr_pkg::RESP_SLVERR;
              reject <= 1'b1;
            end
          end
          sdcr_pkg::ADDR_STATUS: begin
            if (s_axi_wstrb[0] && w_data[sdcr_pkg::STAT_REJECT]) begin
              reject <= 1'b0;
            end
          end
          sdcr_pkg::ADDR_DIV: begin
            if (s_axi_wstrb[0]) begin
              half_div <= w_data[7:0];
            end
          end
          default: s_axi_bresp <= sdcr_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************************
  // read channel
  // ***************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= sdcr_pkg::WORD_RESET;
      s_axi_rresp <= sdcr_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sdcr_pkg::RESP_OKAY;
        case (s_axi_araddr)
          sdcr_pkg::ADDR_DATA: s_axi_rdata <= w_data;
          sdcr_pkg::ADDR_STATUS: s_axi_rdata <= {30'h0000_0000, reject, o_busy};
          sdcr_pkg::ADDR_DIV: s_axi_rdata <= {24'h00_0000, half_div};
          default: begin
            s_axi_rdata <= sdcr_pkg::WORD_RESET;
            s_axi_rresp <= sdcr_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***************************************************
  // serial shifter
  // ***************************************************
  logic [31:0] sh;
  logic [4:0] bits;
  logic [7:0] tmr;
  logic tmr_done;
  logic [7:0] tmr_load;

  assign tmr_done = (tmr == 8'h00);
  assign tmr_load = half_div + sdcr_pkg::HALF_MIN - 8'h01;

  // msb first, data stable over each high phase, then load pulse
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= sdcr_pkg::SH_IDLE;
      sh <= sdcr_pkg::WORD_RESET;
      bits <= 5'h00;
      tmr <= 8'h00;
      link.ser_clk <= 1'b0;
      link.ser_data <= 1'b0;
      link.ser_load <= 1'b0;
    end else if (i_ce) begin
      if (!tmr_done) begin
        tmr <= tmr - 8'h01;
      end
      case (state)
        sdcr_pkg::SH_IDLE: begin
          if (start) begin
            sh <= mask_word(w_data);
            bits <= 5'h1f;
            tmr <= tmr_load;
            link.ser_data <= 1'(mask_word(w_data) >> (sdcr_pkg::WORD_W - 1));
            state <= sdcr_pkg::SH_LOW;
          end
        end
        sdcr_pkg::SH_LOW: begin
          if (tmr_done) begin
            link.ser_clk <= 1'b1;
            tmr <= tmr_load;
            state <= sdcr_pkg::SH_HIGH;
          end
        end
        sdcr_pkg::SH_HIGH: begin
          if (tmr_done) begin
            link.ser_clk <= 1'b0;
            tmr <= tmr_load;
            sh <= {sh[30:0], 1'b0};
            link.ser_data <= sh[30];
            if (bits == 5'h00) begin
              link.ser_load <= 1'b1;
              link.ser_data <= 1'b0;
              state <= sdcr_pkg::SH_LOAD;
            end else begin
              bits <= bits - 5'h01;
              state <= sdcr_pkg::SH_LOW;
            end
          end
        end
        sdcr_pkg::SH_LOAD: begin
          if (tmr_done) begin
            link.ser_load <= 1'b0;
            state <= sdcr_pkg::SH_IDLE;
          end
        end
        default: state <= sdcr_pkg::SH_IDLE;
      endcase
    end
  end

endmodule : sdcr_host

`default_nettype wire

// [testbench/sdcr_props.sv]
// Purpose: link wire checks
// Assumes: one clock, sync reset
// Notes: rebuilds each word from the wires
`default_nettype none
module sdcr_props (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // link wires
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic ck_q, ld_q;
  logic [5:0] nb;
  logic [31:0] w;
  wire logic ld = ser_load & ~ld_q;
  wire logic rise = ser_clk & ~ck_q;
  // edge history of the wires
  always_ff @(posedge i_mclk) begin
    ck_q <= ser_clk;
    ld_q <= ser_load;
  end
  // bits since the last load
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || ser_load) begin
      nb <= 6'h00;
    end else if (rise) begin
      nb <= nb + 6'h01;
    end
  end
  // shadow word, msb first
  always_ff @(posedge i_mclk) begin
    if (rise) begin
      w <= {w[30:0], ser_data};
    end
  end
  a_load_clk_low: assert property (ser_load |-> !ser_clk)
    else $error("load with clock high");
  a_load_held: assert property (ld |-> ser_load [*2])
    else $error("load too short");
  a_data_steady: assert property (ser_clk |-> $stable(ser_data))
    else $error("data moved");
  a_word_length: assert property (ld |-> nb == 6'h20)
    else $error("word length");
  a_select_known: assert property (ld |-> w[3:0] <= 4'hc)
    else $error("bad select");
  a_reserved_zero: assert property (ld && w[3:0] == 4'h0 |-> w[31:22] == 10'h000)
    else $error("reserved bits set");
  a_int_range: assert property (ld && w[3:0] == 4'h0 |->
    (w[20] ? w[19:4] >= 16'h004b : w[19:4] inside {[16'h0017:16'h7fff]}))
    else $error("integer out of range");
  a_aux_below: assert property (ld && w[3:0] == 4'h2 |-> w[31:18] < w[17:4])
    else $error("aux fraction too big");
  a_no_adj_sync: assert property (ld && w[3:0] == 4'h3 |-> !(w[28] && w[29]))
    else $error("adjust with resync");
  c_int: cover property (ld && w[3:0] == 4'h0);
  c_adj: cover property (ld && w[3:0] == 4'h3 && w[28]);
  c_ref: cover property (ld && w[3:0] == 4'h4);
endmodule : sdcr_props
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: host and bank over the link, driven by AXI4-Lite
// Assumes: 50 ns clock, reset 16 cycles
// Notes: fixed-seed random fields
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'h0, i_sys_rst = 1'h1, rin = 1'h0;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdata, rd, f, w4;
  logic awr, wr, bv, arr, rv, busy, cal, mrst, pst, p89, rsy, hld, rdf, lvl, tick, rq;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] nint;
  logic [23:0] frac, acc, ea, ef;
  logic [13:0] aux_fraction_modulus, aux_fraction_numerator;
  logic [3:0] cp;
  logic [8:0] ec;
  logic [2:0] mux, odv;
  logic [31:0] bad [6] = '{32'h0000_0160, 32'h0010_04a0, 32'h0008_0000, 32'h0004_0012,
    32'h3000_0003, 32'h0000_000d};
  int seed = 31, failures, n_checks, cyc, ncal, nmr, i, nps, nfe, ntk;
  sdcr_if u_sdcr_if();
  sdcr_host u_sdcr_host (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(1'h1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .link(u_sdcr_if), .o_busy(busy));
  sdcr_device u_sdcr_device (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(1'h1),
    .link(u_sdcr_if), .i_ref_in(rin), .o_int_value(nint), .o_presc_89(p89),
    .o_int_range_err(), .o_autocal_start(cal), .o_main_fraction_numerator(frac),
    .o_aux_fraction_numerator(aux_fraction_numerator), .o_aux_fraction_modulus(aux_fraction_modulus),
    .o_modulator_reset(mrst), .o_resync_active(rsy), .o_phase_step(pst),
    .o_phase_accum(acc), .o_mux_select(mux), .o_pump_current_code(cp),
    .o_ref_differential(rdf), .o_mux_level_33(lvl), .o_counter_hold(hld),
    .o_out_div_select(odv), .o_pfd_tick(tick));
  sdcr_props u_sdcr_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .ser_clk(u_sdcr_if.ser_clk), .ser_data(u_sdcr_if.ser_data), .ser_load(u_sdcr_if.ser_load));
  always #25 i_mclk = ~i_mclk;
  // reference noise, pulse counts, hang guard
  always @(posedge i_mclk) begin
    rin <= 1'($random(seed));
    ncal <= ncal + int'(cal);
    nmr <= nmr + int'(mrst);
    nps <= nps + int'(pst);
    // own count of reference falling edges, against the divider's ticks
    rq <= i_sys_rst ? 1'h0 : rin;
    nfe <= nfe + int'(!i_sys_rst && rq && !rin);
    ntk <= ntk + int'(tick);
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****
  // bus tasks
  // ****
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'h1) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  // live reference fields that a committed register 4 word shows
  function automatic logic [8:0] exp_live4(input logic [31:0] w);
    return {w[29:27], w[13:10], w[9], w[8]};
  endfunction : exp_live4
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_on, w_on;
    @(posedge i_mclk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    aw_on = 1'h1;
    w_on = 1'h1;
    while (aw_on || w_on) begin
      @(posedge i_mclk);
      if (aw_on && awr) begin
        awv <= 1'h0;
        aw_on = 1'h0;
      end
      if (w_on && wr) begin
        wv <= 1'h0;
        w_on = 1'h0;
      end
    end
    while (bv !== 1'h1) @(posedge i_mclk);
    resp = bresp;
    bry <= 1'h0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge i_mclk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do @(posedge i_mclk); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge i_mclk); while (rv !== 1'h1);
    rd = rdata;
    resp = rresp;
    rry <= 1'h0;
  endtask : axr
  // one word over the link, then wait for the shifter to go idle
  task automatic send(input logic [31:0] d, input logic no);
    axw(sdcr_pkg::ADDR_DATA, d);
    chk(resp === (no ? sdcr_pkg::RESP_SLVERR : sdcr_pkg::RESP_OKAY), "response");
    repeat (2) @(posedge i_mclk);
    while (busy !== 1'h0) @(posedge i_mclk);
    repeat (4) @(posedge i_mclk);
  endtask : send
  task tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // staged writes, commit, refusals, status
  initial begin
    ea = 24'h00_0000;
    ef = 24'h00_0000;
    ec = 9'h000;
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'h0;
    axw(sdcr_pkg::ADDR_DIV, 32'h0000_0000);
    for (i = 0; i < 3; i++) begin
      f = $random(seed);
      send({4'h0, f[23:0], 4'h1}, 1'h0);
      send({6'h00, f[7:0], 6'h01, f[31:24], 4'h2}, 1'h0);
      send({4'h5, f[23:0], 4'h3}, 1'h0);
      w4 = {2'h0, f[14:12], 2'h0, 10'h001, 1'h0, f[11:8], f[15], f[16], 8'h04};
      send(w4, 1'h0);
      chk(frac === ef && {mux, cp, rdf, lvl} === ec, "staged early");
      send({10'h000, 1'h1, 1'h0, 16'h0017 + 16'(i), 4'h0}, 1'h0);
      ef = f[23:0];
      ec = exp_live4(w4);
      ea = ea + f[23:0];
      chk(nint === 16'h0017 + 16'(i), "integer");
      chk(frac === ef, "fraction");
      chk({mux, cp, rdf, lvl} === ec, "reference fields");
      chk({aux_fraction_numerator, aux_fraction_modulus} === {6'h00, f[7:0], 6'h01, f[31:24]}, "modulus");
      chk(acc === ea, "phase");
      chk(ncal === i + 1 && nps === i + 1 && nmr === 0, "pulses");
      chk((nfe - ntk) inside {0, 1}, "pfd ticks");
    end
    send(32'h2000_0003, 1'h0);
    send(32'h0000_1012, 1'h0);
    send(32'h0000_4014, 1'h0);
    send(32'h0010_04b0, 1'h0);
    chk(nmr === 1 && ncal === 3 && acc === ea && nps === 3, "reset pulse");
    chk(p89 === 1'h1 && hld === 1'h1, "prescaler, hold");
    chk(rsy === 1'h1, "resync");
    send(32'h00a0_0006, 1'h0);
    chk(odv === 3'h0, "divider early");
    send(32'h0010_04b0, 1'h0);
    chk(odv === 3'h5, "divider");
    for (i = 0; i < 6; i++) begin
      send(bad[i], 1'h1);
    end
    chk(nint === 16'h004b, "refused applied");
    axr(sdcr_pkg::ADDR_STATUS);
    chk(rd[sdcr_pkg::STAT_REJECT] === 1'h1, "reject flag");
    axr(8'h0c);
    chk(resp === sdcr_pkg::RESP_SLVERR, "unmapped");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
